/* design/ffltb_bank.sv */
module ffltb_bank
  import ffltb_pkg::*;
#(
  parameter int N_OUT = ffltb_pkg::NOUT
)
(
  input wire logic sys_clk_i,
  input wire logic arst_n_i,
  input wire ffltb_pkg::ffltb_cmd_t cmd_i,
  output logic rvalid_o,
  output logic [ffltb_pkg::DW-1:0] rdata_o,
  input wire ffltb_pkg::ffltb_meas_t [N_OUT-1:0] meas_i,
  input wire logic [ffltb_pkg::DW-1:0] vin_meas_i,
  input wire logic [N_OUT-1:0][ffltb_pkg::DW-1:0] vout_req_i,
  output logic [N_OUT-1:0][ffltb_pkg::DW-1:0] vout_target_o,
  output logic [N_OUT-1:0] output_overvoltage_flag_o,
  output logic [N_OUT-1:0] out_uv_flag_o,
  output logic [N_OUT-1:0] stage_ot_flag_o,
  output logic input_ov_flag_o,
  output logic input_lockout_o,
  output logic host_alert_pin_n_o,
  output logic thermal_warning_pin_n_o
);
  import ffltb_pkg::*;

  localparam int PW = (N_OUT > 1) ? $clog2(N_OUT) : 1;

  logic [PW-1:0] page;
  logic [DW-1:0] out_ov_wr [N_OUT];
  logic [DW-1:0] out_ov_act [N_OUT];
  logic [DW-1:0] out_uv_lim [N_OUT];
  logic [DW-1:0] stage_ot_lim [N_OUT];
  logic [DW-1:0] ot_warn_lim [N_OUT];
  logic [DW-1:0] vout_ceil [N_OUT];
  logic [DW-1:0] in_ov_wr;
  logic [DW-1:0] in_ov_act;
  logic [DW-1:0] in_uv_wr;
  logic [DW-1:0] in_uv_act;
  ffltb_flags_t flags [N_OUT];
  logic [N_OUT-1:0] ev_out_ov;
  logic [N_OUT-1:0] ev_out_uv;
  logic [N_OUT-1:0] ev_stage_ot;
  logic [N_OUT-1:0] ev_ot_warn;
  logic [N_OUT-1:0] out_on;
  logic st_out_ov;
  logic st_out_uv;
  logic st_in_ov;
  logic st_in_uv;
  logic st_ot_fault;
  logic st_ot_warn;
  logic wr_en;
  logic rd_en;
  logic commit;
  logic clear;
  logic ev_in_ov;
  logic ev_in_uv;
  logic [7:0] status_byte;
  logic [DW-1:0] status_word;
  logic [7:0] status_temp;
  logic [DW-1:0] next_rdata;

  assign wr_en = cmd_i.valid && cmd_i.write;
  assign rd_en = cmd_i.valid && !cmd_i.write;
  assign commit = wr_en && (cmd_i.code == CMD_COMMIT);
  assign clear = wr_en && (cmd_i.code == CMD_CLEAR_FAULTS);
  // input limits compare against the applied copies only
  assign ev_in_ov = vin_meas_i > in_ov_act;
  assign ev_in_uv = vin_meas_i < in_uv_act;

  // page select; a page beyond the last output is ignored
  always_ff @(posedge sys_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      page <= '0;
    else if (wr_en && cmd_i.code == CMD_PAGE && cmd_i.wdata < DW'(N_OUT))
      page <= cmd_i.wdata[PW-1:0];
  end

  // shared input limits: written copy, taken by a CMD_IN_OV or CMD_IN_UV host write on any page
  always_ff @(posedge sys_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      in_ov_wr <= RST_IN_OV;
      in_uv_wr <= RST_IN_UV;
    end
    else
    begin
      if (wr_en && cmd_i.code == CMD_IN_OV)
        in_ov_wr <= cmd_i.wdata;
      if (wr_en && cmd_i.code == CMD_IN_UV)
        in_uv_wr <= cmd_i.wdata;
    end
  end

  // applied copies move only on commit, so a half-written pair never acts
  always_ff @(posedge sys_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      in_ov_act <= RST_IN_OV;
      in_uv_act <= RST_IN_UV;
    end
    else if (commit)
    begin
      in_ov_act <= in_ov_wr;
      in_uv_act <= in_uv_wr;
    end
  end

  // a new event in the clearing cycle keeps the bit set
  function automatic logic sticky_next(input logic ev, input logic cur, input logic clr);
    sticky_next = ev || (cur && !clr);
  endfunction : sticky_next

  genvar g;
  generate
    for (g = 0; g < N_OUT; g++)
    begin : g_out
      logic sel;
      assign sel = wr_en && (page == PW'(g)) && ffltb_is_paged(cmd_i.code);

      always_ff @(posedge sys_clk_i or negedge arst_n_i)
      begin
        if (!arst_n_i)
        begin
          out_ov_wr[g] <= RST_OUT_OV;
          out_ov_act[g] <= RST_OUT_OV;
          out_uv_lim[g] <= RST_OUT_UV;
          stage_ot_lim[g] <= RST_STAGE_OT;
          ot_warn_lim[g] <= RST_OT_WARN;
          vout_ceil[g] <= RST_VOUT_CEIL;
        end
        else
        begin
          if (sel)
          begin
            unique case (cmd_i.code)
              CMD_OUT_OV: out_ov_wr[g] <= cmd_i.wdata;
              CMD_OUT_UV: out_uv_lim[g] <= cmd_i.wdata;
              CMD_STAGE_OT: stage_ot_lim[g] <= cmd_i.wdata;
              CMD_OT_WARN: ot_warn_lim[g] <= cmd_i.wdata;
              CMD_VOUT_CEIL: vout_ceil[g] <= cmd_i.wdata;
              default: ;
            endcase
          end
          if (commit)
            out_ov_act[g] <= out_ov_wr[g];
        end
      end

      ffltb_chan u_chan (
        .meas_i(meas_i[g]),
        .ov_lim_i(out_ov_act[g]),
        .uv_lim_i(out_uv_lim[g]),
        .ot_lim_i(stage_ot_lim[g]),
        .warn_lim_i(ot_warn_lim[g]),
        .flags_o(flags[g])
      );

      assign ev_out_ov[g] = flags[g].out_ov;
      assign ev_out_uv[g] = flags[g].out_uv;
      assign ev_stage_ot[g] = flags[g].stage_ot;
      assign ev_ot_warn[g] = flags[g].ot_warn;
      assign out_on[g] = meas_i[g].enabled;

      // ceiling acts at once; no commit needed
      always_ff @(posedge sys_clk_i or negedge arst_n_i)
      begin
        if (!arst_n_i)
          vout_target_o[g] <= '0;
        else if (vout_req_i[g] > vout_ceil[g])
          vout_target_o[g] <= vout_ceil[g];
        else
          vout_target_o[g] <= vout_req_i[g];
      end
    end
  endgenerate

  // sticky status; a new event in the clearing cycle wins
  always_ff @(posedge sys_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      st_out_ov <= 1'b0;
      st_out_uv <= 1'b0;
      st_in_ov <= 1'b0;
      st_in_uv <= 1'b0;
      st_ot_fault <= 1'b0;
      st_ot_warn <= 1'b0;
    end
    else
    begin
      st_out_ov <= sticky_next(|ev_out_ov, st_out_ov, clear);
      st_out_uv <= sticky_next(|ev_out_uv, st_out_uv, clear);
      st_in_ov <= sticky_next(ev_in_ov, st_in_ov, clear);
      st_in_uv <= sticky_next(ev_in_uv, st_in_uv, clear);
      st_ot_fault <= sticky_next(|ev_stage_ot, st_ot_fault, clear);
      st_ot_warn <= sticky_next(|ev_ot_warn, st_ot_warn, clear);
    end
  end

  always_comb
  begin
    status_byte = '0;
    status_byte[SB_OFF] = ~|out_on;
    status_byte[SB_OUT_OV] = st_out_ov;
    status_byte[SB_IN_UV] = st_in_uv;
    status_byte[SB_TEMP] = st_ot_warn || st_ot_fault;
    // low byte of the word mirrors the status byte
    status_word = {8'h00, status_byte};
    status_word[SW_VOUT] = st_out_ov || st_out_uv;
    status_word[SW_INPUT] = st_in_ov || st_in_uv;
    status_temp = '0;
    status_temp[ST_OT_FAULT] = st_ot_fault;
    status_temp[ST_OT_WARN] = st_ot_warn;
  end

  // readback returns the written copy, applied or not
  always_comb
  begin
    next_rdata = '0;
    unique case (cmd_i.code)
      CMD_PAGE: next_rdata = DW'(page);
      CMD_VOUT_CEIL: next_rdata = vout_ceil[page];
      CMD_OUT_OV: next_rdata = out_ov_wr[page];
      CMD_OUT_UV: next_rdata = out_uv_lim[page];
      CMD_STAGE_OT: next_rdata = stage_ot_lim[page];
      CMD_OT_WARN: next_rdata = ot_warn_lim[page];
      CMD_IN_OV: next_rdata = in_ov_wr;
      CMD_IN_UV: next_rdata = in_uv_wr;
      CMD_STATUS_BYTE: next_rdata = DW'(status_byte);
      CMD_STATUS_WORD: next_rdata = status_word;
      CMD_STATUS_TEMP: next_rdata = DW'(status_temp);
      default: next_rdata = '0;
    endcase
  end

  always_ff @(posedge sys_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      rvalid_o <= 1'b0;
      rdata_o <= '0;
    end
    else
    begin
      rvalid_o <= rd_en;
      if (rd_en)
        rdata_o <= next_rdata;
    end
  end

  always_ff @(posedge sys_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      output_overvoltage_flag_o <= '0;
      out_uv_flag_o <= '0;
      stage_ot_flag_o <= '0;
      input_ov_flag_o <= 1'b0;
      input_lockout_o <= 1'b0;
    end
    else
    begin
      output_overvoltage_flag_o <= ev_out_ov;
      out_uv_flag_o <= ev_out_uv;
      stage_ot_flag_o <= ev_stage_ot;
      input_ov_flag_o <= ev_in_ov;
      input_lockout_o <= ev_in_uv;
    end
  end

  // pins follow the sticky bits, so they stay low until faults are cleared
  always_ff @(posedge sys_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      host_alert_pin_n_o <= 1'b1;
      thermal_warning_pin_n_o <= 1'b1;
    end
    else
    begin
      host_alert_pin_n_o <= !(st_out_ov || st_out_uv || st_in_ov || st_in_uv
        || st_ot_fault || st_ot_warn);
      thermal_warning_pin_n_o <= !st_ot_warn;
    end
  end
endmodule : ffltb_bank

/* design/ffltb_pkg.sv */
package ffltb_pkg;
  localparam int DW = 16;
  localparam int NOUT = 2;

  localparam logic [7:0] CMD_PAGE = 8'h00;
  localparam logic [7:0] CMD_CLEAR_FAULTS = 8'h03;
  localparam logic [7:0] CMD_VOUT_CEIL = 8'h24;
  localparam logic [7:0] CMD_OUT_OV = 8'h40;
  localparam logic [7:0] CMD_OUT_UV = 8'h44;
  localparam logic [7:0] CMD_STAGE_OT = 8'h4f;
  localparam logic [7:0] CMD_OT_WARN = 8'h51;
  localparam logic [7:0] CMD_IN_OV = 8'h55;
  localparam logic [7:0] CMD_IN_UV = 8'h59;
  localparam logic [7:0] CMD_STATUS_BYTE = 8'h78;
  localparam logic [7:0] CMD_STATUS_WORD = 8'h79;
  localparam logic [7:0] CMD_STATUS_TEMP = 8'h7d;
  localparam logic [7:0] CMD_COMMIT = 8'he7;

  localparam logic [DW-1:0] RST_OUT_OV = 16'h076c;
  localparam logic [DW-1:0] RST_OUT_UV = 16'h0000;
  localparam logic [DW-1:0] RST_STAGE_OT = 16'h007d;
  localparam logic [DW-1:0] RST_OT_WARN = 16'h07d0;
  localparam logic [DW-1:0] RST_IN_OV = 16'h36b0;
  localparam logic [DW-1:0] RST_IN_UV = 16'h1f40;
  localparam logic [DW-1:0] RST_VOUT_CEIL = 16'h08fc;

  localparam int SB_OFF = 6;
  localparam int SB_OUT_OV = 5;
  localparam int SB_IN_UV = 3;
  localparam int SB_TEMP = 2;
  localparam int SW_VOUT = 15;
  localparam int SW_INPUT = 13;
  localparam int ST_OT_FAULT = 7;
  localparam int ST_OT_WARN = 6;

  typedef struct packed {
    logic valid;
    logic write;
    logic [7:0] code;
    logic [DW-1:0] wdata;
  } ffltb_cmd_t;

  typedef struct packed {
    logic [DW-1:0] vout;
    logic signed [DW-1:0] temp;
    logic enabled;
    logic ramping;
  } ffltb_meas_t;

  typedef struct packed {
    logic out_ov;
    logic out_uv;
    logic stage_ot;
    logic ot_warn;
  } ffltb_flags_t;

  function automatic logic ffltb_is_paged(input logic [7:0] code);
    ffltb_is_paged = (code == CMD_OUT_OV) || (code == CMD_OUT_UV) || (code == CMD_STAGE_OT)
      || (code == CMD_OT_WARN) || (code == CMD_VOUT_CEIL);
  endfunction : ffltb_is_paged
endpackage : ffltb_pkg

/* design/ffltb_chan.sv */
module ffltb_chan
  import ffltb_pkg::*;
(
  input wire ffltb_pkg::ffltb_meas_t meas_i,
  input wire logic [ffltb_pkg::DW-1:0] ov_lim_i,
  input wire logic [ffltb_pkg::DW-1:0] uv_lim_i,
  input wire logic signed [ffltb_pkg::DW-1:0] ot_lim_i,
  input wire logic signed [ffltb_pkg::DW-1:0] warn_lim_i,
  output ffltb_pkg::ffltb_flags_t flags_o
);
  always_comb
  begin
    flags_o.out_ov = meas_i.vout > ov_lim_i;
    // masked during ramp and while disabled
    flags_o.out_uv = (meas_i.vout < uv_lim_i) && meas_i.enabled && !meas_i.ramping;
    flags_o.stage_ot = meas_i.temp > ot_lim_i;
    flags_o.ot_warn = meas_i.temp > warn_lim_i;
  end
endmodule : ffltb_chan

/* sim/ffltb_host.sv */
module ffltb_host
  import ffltb_pkg::*;
(
  input wire logic clk_i,
  output ffltb_pkg::ffltb_cmd_t cmd_o,
  input wire logic rvalid_i,
  input wire logic [ffltb_pkg::DW-1:0] rdata_i
);
  timeunit 1ns;
  timeprecision 1ns;
  initial cmd_o = '0;
  // idle bus shows the inverse of the last word, never a stale copy
  task automatic wr(input logic [7:0] c, input logic [DW-1:0] d);
    @(posedge clk_i);
    cmd_o <= '{1'b1, 1'b1, c, d};
    @(posedge clk_i);
    cmd_o <= '{1'b0, 1'b0, ~c, ~d};
  endtask : wr
  // d stays unknown when no answer comes, so the caller's compare fails
  task automatic rd(input logic [7:0] c, output logic [DW-1:0] d);
    d = 'x;
    @(posedge clk_i);
    cmd_o <= '{1'b1, 1'b0, c, 16'h0000};
    @(posedge clk_i);
    cmd_o <= '{1'b0, 1'b0, ~c, 16'hffff};
    for (int i = 0; i < 4; i++)
    begin
      @(posedge clk_i);
      if (rvalid_i === 1'b1)
      begin
        d = rdata_i;
        break;
      end
    end
  endtask : rd
endmodule : ffltb_host

/* sim/ffltb_bank_asserts.sv */
module ffltb_bank_asserts
  import ffltb_pkg::*;
#(
  parameter int N_OUT = 2
)
(
  input wire logic sys_clk_i,
  input wire logic arst_n_i,
  input wire ffltb_pkg::ffltb_cmd_t cmd_i,
  input wire logic rvalid_o,
  input wire logic [ffltb_pkg::DW-1:0] rdata_o,
  input wire ffltb_pkg::ffltb_meas_t [N_OUT-1:0] meas_i,
  input wire logic [N_OUT-1:0][ffltb_pkg::DW-1:0] vout_req_i,
  input wire logic [N_OUT-1:0][ffltb_pkg::DW-1:0] vout_target_o,
  input wire logic [N_OUT-1:0] output_overvoltage_flag_o,
  input wire logic [N_OUT-1:0] out_uv_flag_o,
  input wire logic [N_OUT-1:0] stage_ot_flag_o,
  input wire logic input_lockout_o,
  input wire logic host_alert_pin_n_o,
  input wire logic thermal_warning_pin_n_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!arst_n_i);
  AST_RD_ANS: assert property (cmd_i.valid && !cmd_i.write |=> rvalid_o)
    else $error("read not answered");
  AST_RD_HOLD: assert property (!rvalid_o |-> $stable(rdata_o))
    else $error("read data moved");
  AST_CEIL: assert property (vout_target_o[0] <= $past(vout_req_i[0]))
    else $error("target above request");
  AST_UV_MASK: assert property (!meas_i[0].enabled || meas_i[0].ramping
    |=> !out_uv_flag_o[0]) else $error("undervoltage not masked");
  AST_OV_ALERT: assert property (output_overvoltage_flag_o[0] |=> !host_alert_pin_n_o)
    else $error("overvoltage without alert");
  AST_OT_ALERT: assert property ((|stage_ot_flag_o) |=> !host_alert_pin_n_o)
    else $error("overtemp without alert");
  AST_LOCK_ALERT: assert property (input_lockout_o |=> !host_alert_pin_n_o)
    else $error("lockout without alert");
  AST_WARN_ALERT: assert property (!thermal_warning_pin_n_o |-> !host_alert_pin_n_o)
    else $error("warning without alert");
endmodule : ffltb_bank_asserts
bind ffltb_bank ffltb_bank_asserts #(.N_OUT(N_OUT)) u_ffltb_bank_asserts (.sys_clk_i,
  .arst_n_i, .cmd_i, .rvalid_o, .rdata_o, .meas_i, .vout_req_i, .vout_target_o,
  .output_overvoltage_flag_o, .out_uv_flag_o, .stage_ot_flag_o, .input_lockout_o,
  .host_alert_pin_n_o, .thermal_warning_pin_n_o);

/* sim/fault_limit_threshold_bank_tb_top.sv */
module fault_limit_threshold_bank_tb_top
  import ffltb_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk_i = 1'b0;
  logic arst_n_i = 1'b0;
  ffltb_cmd_t cmd_i;
  logic rvalid_o, input_ov_flag_o, input_lockout_o, host_alert_pin_n_o, thermal_warning_pin_n_o;
  logic [DW-1:0] rdata_o, vin_meas_i, got;
  ffltb_meas_t [1:0] meas_i;
  logic [1:0][DW-1:0] vout_req_i, vout_target_o;
  logic [1:0] output_overvoltage_flag_o, out_uv_flag_o, stage_ot_flag_o;
  int miscompares = 0;
  int checks = 0;
  localparam logic [7:0] CODES [7] = '{CMD_OUT_OV, CMD_OUT_UV, CMD_STAGE_OT, CMD_OT_WARN,
    CMD_IN_OV, CMD_IN_UV, CMD_VOUT_CEIL};
  localparam logic [15:0] RSTS [7] = '{RST_OUT_OV, RST_OUT_UV, RST_STAGE_OT, RST_OT_WARN,
    RST_IN_OV, RST_IN_UV, RST_VOUT_CEIL};
  always #20 sys_clk_i = ~sys_clk_i;
  ffltb_bank u_ffltb_bank (.sys_clk_i, .arst_n_i, .cmd_i, .rvalid_o, .rdata_o, .meas_i,
    .vin_meas_i, .vout_req_i, .vout_target_o, .output_overvoltage_flag_o, .out_uv_flag_o,
    .stage_ot_flag_o, .input_ov_flag_o, .input_lockout_o, .host_alert_pin_n_o,
    .thermal_warning_pin_n_o);
  ffltb_host u_ffltb_host (.clk_i(sys_clk_i), .cmd_o(cmd_i), .rvalid_i(rvalid_o),
    .rdata_i(rdata_o));
  task automatic chk(input string n, input logic [DW-1:0] e, input logic [DW-1:0] s);
    checks++;
    if (s !== e)
    begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic rchk(input logic [7:0] c, input logic [DW-1:0] e);
    u_ffltb_host.rd(c, got);
    chk($sformatf("read %h", c), e, got);
    // no answer within the bound ends the run as a failure
    if ($isunknown(got))
      stop_test();
  endtask : rchk
  task automatic wt;
    repeat (3) @(posedge sys_clk_i);
  endtask : wt
  task automatic stop_test;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : stop_test
  initial
  begin
    vin_meas_i = 16'h2000;
    vout_req_i = {16'h0900, 16'h0600};
    meas_i[0] = '{16'h0600, 16'h0060, 1'b1, 1'b0};
    meas_i[1] = meas_i[0];
    repeat (20) @(posedge sys_clk_i);
    arst_n_i <= 1'b1;
    wt;
    chk("thermal_warning_pin", 16'h1, 16'(thermal_warning_pin_n_o));
    chk("tgt1", 16'h08fc, vout_target_o[1]);
    chk("tgt0", 16'h0600, vout_target_o[0]);
    chk("alert", 16'h1, 16'(host_alert_pin_n_o));
    for (int i = 0; i < 7; i++)
      rchk(CODES[i], RSTS[i]);
    u_ffltb_host.wr(CMD_OUT_OV, 16'h0500);
    rchk(CMD_OUT_OV, 16'h0500);
    wt;
    chk("ovf0", 16'h0, 16'(output_overvoltage_flag_o[0]));
    u_ffltb_host.wr(CMD_PAGE, 16'h0001);
    rchk(CMD_OUT_OV, 16'h076c);
    u_ffltb_host.wr(CMD_PAGE, 16'h0000);
    u_ffltb_host.wr(CMD_COMMIT, 16'h0000);
    wt;
    chk("ovf0", 16'h1, 16'(output_overvoltage_flag_o[0]));
    chk("ovf1", 16'h0, 16'(output_overvoltage_flag_o[1]));
    rchk(CMD_STATUS_BYTE, 16'h0020);
    u_ffltb_host.wr(CMD_OUT_UV, 16'h0400);
    meas_i[0] <= '{16'h0100, 16'h0060, 1'b1, 1'b1};
    wt;
    chk("uv ramp", 16'h0, 16'(out_uv_flag_o[0]));
    meas_i[0] <= '{16'h0100, 16'h0060, 1'b0, 1'b0};
    wt;
    chk("uv off", 16'h0, 16'(out_uv_flag_o[0]));
    meas_i[0] <= '{16'h0100, 16'h0060, 1'b1, 1'b0};
    meas_i[1] <= '{16'h0600, 16'hff80, 1'b1, 1'b0};
    wt;
    chk("uv on", 16'h1, 16'(out_uv_flag_o[0]));
    chk("ot neg", 16'h0, 16'(stage_ot_flag_o[1]));
    meas_i[1] <= '{16'h0600, 16'h007e, 1'b1, 1'b0};
    wt;
    chk("ot", 16'h1, 16'(stage_ot_flag_o[1]));
    rchk(CMD_STATUS_TEMP, 16'h0080);
    u_ffltb_host.wr(CMD_OT_WARN, 16'h0050);
    wt;
    chk("thermal_warning_pin", 16'h0, 16'(thermal_warning_pin_n_o));
    chk("alert", 16'h0, 16'(host_alert_pin_n_o));
    rchk(CMD_STATUS_TEMP, 16'h00c0);
    rchk(CMD_STATUS_WORD, 16'h8024);
    u_ffltb_host.wr(CMD_IN_UV, 16'h2100);
    u_ffltb_host.wr(CMD_IN_OV, 16'h1f00);
    wt;
    chk("lock", 16'h0, 16'(input_lockout_o));
    chk("inov", 16'h0, 16'(input_ov_flag_o));
    u_ffltb_host.wr(CMD_COMMIT, 16'h0000);
    wt;
    chk("lock", 16'h1, 16'(input_lockout_o));
    chk("inov", 16'h1, 16'(input_ov_flag_o));
    u_ffltb_host.wr(CMD_VOUT_CEIL, 16'h0580);
    wt;
    chk("tgt0", 16'h0580, vout_target_o[0]);
    u_ffltb_host.wr(CMD_CLEAR_FAULTS, 16'h0000);
    rchk(CMD_STATUS_BYTE, 16'h000c);
    rchk(CMD_STATUS_WORD, 16'ha00c);
    arst_n_i <= 1'b0;
    repeat (2) @(posedge sys_clk_i);
    arst_n_i <= 1'b1;
    wt;
    rchk(CMD_OUT_OV, RST_OUT_OV);
    rchk(CMD_IN_UV, RST_IN_UV);
    chk("lock", 16'h0, 16'(input_lockout_o));
    stop_test();
  end
endmodule : fault_limit_threshold_bank_tb_top
